// [rtl/tdj_judge.sv]
// dual-touch judgment parameters, pressure and spread judgment, settling delay
// Notes on behaviour
// - resistor-sense measurement waits selected 5 to 700 us before conversion; 5 us at reset.
// - single pressure low when ratio divided by four exceeds single limit, reset C0.
// - dual pressure low when ratio exceeds dual limit, reset C0.
// - dual touch when smoothed spread strictly exceeds detect limit, reset 08.
// - spread offset, reset 00, corrects the spread metric.
// - X dual quantity uses slope (reset 02) and bias (reset 40).
// - Y dual quantity uses slope (reset 02) and bias (reset 40).
// - calibration refreshes X and Y references only when update control is one.
`default_nettype none
`include "tdj_map.svh"
module tdj_judge
    import tdj_pkg::*;
#(
    parameter int RATIO_W  = 10,
    parameter int SPREAD_W = 8,
    parameter int DIST_W   = 12,
    parameter int RES_W    = 16,
    parameter logic [`TDJ_SETTLE_CW-1:0] SETTLE_CYC [8] = '{
        `TDJ_SETTLE_CW'(`TDJ_SET_US0 * `TDJ_CLK_MHZ), `TDJ_SETTLE_CW'(`TDJ_SET_US1 * `TDJ_CLK_MHZ),
        `TDJ_SETTLE_CW'(`TDJ_SET_US2 * `TDJ_CLK_MHZ), `TDJ_SETTLE_CW'(`TDJ_SET_US3 * `TDJ_CLK_MHZ),
        `TDJ_SETTLE_CW'(`TDJ_SET_US4 * `TDJ_CLK_MHZ), `TDJ_SETTLE_CW'(`TDJ_SET_US5 * `TDJ_CLK_MHZ),
        `TDJ_SETTLE_CW'(`TDJ_SET_US6 * `TDJ_CLK_MHZ), `TDJ_SETTLE_CW'(`TDJ_SET_US7 * `TDJ_CLK_MHZ)}
) (
    input  wire logic                CLK_IN,
    input  wire logic                RST_B_IN,
    input  wire logic                CE_IN,
    input  wire logic [7:0]          REG_ADDR_IN,
    input  wire logic [7:0]          REG_WDATA_IN,
    input  wire logic                REG_WR_IN,
    input  wire logic                REG_RD_IN,
    output logic      [7:0]          REG_RDATA_OUT,
    input  wire logic                MEAS_VALID_IN,
    input  wire logic [RATIO_W-1:0]  PRESSURE_RATIO_IN,
    input  wire logic [SPREAD_W-1:0] SPREAD_RAW_IN,
    input  wire logic                SMOOTH_EN_IN,
    input  wire logic [DIST_W-1:0]   X_DIST_IN,
    input  wire logic [DIST_W-1:0]   Y_DIST_IN,
    input  wire logic                CALIB_IN,
    input  wire logic                REF_UPDATE_EN_IN,
    input  wire logic [RES_W-1:0]    X_RES_IN,
    input  wire logic [RES_W-1:0]    Y_RES_IN,
    input  wire logic                DRIVER_ON_IN,
    input  wire logic                RES_PANEL_IN,
    output logic                     SETTLING_OUT,
    output logic                     START_CONV_OUT,
    output logic                     PRESS_LOW_SINGLE_OUT,
    output logic                     PRESS_LOW_DUAL_OUT,
    output logic                     DUAL_TOUCH_OUT,
    output logic      [SPREAD_W-1:0] SMOOTHED_SPREAD_OUT,
    output logic      [DIST_W-1:0]   X_DUAL_OUT,
    output logic      [DIST_W-1:0]   Y_DUAL_OUT,
    output logic      [RES_W-1:0]    X_REF_OUT,
    output logic      [RES_W-1:0]    Y_REF_OUT,
    output logic      [2:0]          RATIO_CORRECTION_OUT
);
    tdj_cfg_t                  cfg;
    tdj_judge_t                next_judge;
    tdj_state_t                state;
    logic [`TDJ_SETTLE_CW-1:0] settle_cnt;
    logic [SPREAD_W-1:0]       spread_metric;
    logic [SPREAD_W-1:0]       next_smooth;
    logic [SPREAD_W:0]         smooth_sum;
    logic [7:0]                rd_mux;

    // register writes; reserved bits of the interval register are dropped
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cfg.ratio_correction    <= `TDJ_RST_CORR;
            cfg.settle_delay_select <= `TDJ_RST_SETTLE;
            cfg.single_press_limit  <= `TDJ_RST_SPRESS;
            cfg.dual_press_limit    <= `TDJ_RST_DPRESS;
            cfg.dual_detect_limit   <= `TDJ_RST_DETECT;
            cfg.spread_offset       <= `TDJ_RST_OFFSET;
            cfg.x_slope_const       <= `TDJ_RST_SLOPE;
            cfg.x_bias_const        <= `TDJ_RST_BIAS;
            cfg.y_slope_const       <= `TDJ_RST_SLOPE;
            cfg.y_bias_const        <= `TDJ_RST_BIAS;
        end else if (CE_IN && REG_WR_IN) begin
            case (REG_ADDR_IN)
                `TDJ_ADDR_CFG: begin
                    // correction kept as written; host keeps it below the limit
                    cfg.ratio_correction    <= REG_WDATA_IN[`TDJ_CORR_MSB:`TDJ_CORR_LSB];
                    cfg.settle_delay_select <= REG_WDATA_IN[`TDJ_SETTLE_MSB:`TDJ_SETTLE_LSB];
                end
                `TDJ_ADDR_SPRESS: cfg.single_press_limit <= REG_WDATA_IN;
                `TDJ_ADDR_DPRESS: cfg.dual_press_limit   <= REG_WDATA_IN;
                `TDJ_ADDR_DETECT: cfg.dual_detect_limit  <= REG_WDATA_IN;
                `TDJ_ADDR_OFFSET: cfg.spread_offset      <= REG_WDATA_IN;
                `TDJ_ADDR_XSLOPE: cfg.x_slope_const      <= REG_WDATA_IN;
                `TDJ_ADDR_XBIAS:  cfg.x_bias_const       <= REG_WDATA_IN;
                `TDJ_ADDR_YSLOPE: cfg.y_slope_const      <= REG_WDATA_IN;
                `TDJ_ADDR_YBIAS:  cfg.y_bias_const       <= REG_WDATA_IN;
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        rd_mux = 8'h00;
        case (REG_ADDR_IN)
            `TDJ_ADDR_CFG: begin
                rd_mux[`TDJ_CORR_MSB:`TDJ_CORR_LSB]     = cfg.ratio_correction;
                rd_mux[`TDJ_SETTLE_MSB:`TDJ_SETTLE_LSB] = cfg.settle_delay_select;
            end
            `TDJ_ADDR_SPRESS: rd_mux = cfg.single_press_limit;
            `TDJ_ADDR_DPRESS: rd_mux = cfg.dual_press_limit;
            `TDJ_ADDR_DETECT: rd_mux = cfg.dual_detect_limit;
            `TDJ_ADDR_OFFSET: rd_mux = cfg.spread_offset;
            `TDJ_ADDR_XSLOPE: rd_mux = cfg.x_slope_const;
            `TDJ_ADDR_XBIAS:  rd_mux = cfg.x_bias_const;
            `TDJ_ADDR_YSLOPE: rd_mux = cfg.y_slope_const;
            `TDJ_ADDR_YBIAS:  rd_mux = cfg.y_bias_const;
            default:          rd_mux = 8'h00;
        endcase
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else if (CE_IN && REG_RD_IN) begin
            REG_RDATA_OUT <= rd_mux;
        end
    end

    assign RATIO_CORRECTION_OUT = cfg.ratio_correction;

    // offset correction clamps at zero rather than wrapping to a huge spread
    always_comb begin
        if (SPREAD_RAW_IN > SPREAD_W'(cfg.spread_offset)) begin
            spread_metric = SPREAD_RAW_IN - SPREAD_W'(cfg.spread_offset);
        end else begin
            spread_metric = '0;
        end
        smooth_sum  = {1'b0, SMOOTHED_SPREAD_OUT} + {1'b0, spread_metric};
        next_smooth = SMOOTH_EN_IN ? smooth_sum[SPREAD_W:1] : spread_metric;
        next_judge.press_low_single = PRESSURE_RATIO_IN[RATIO_W-1:2] > (RATIO_W-2)'(cfg.single_press_limit);
        next_judge.press_low_dual   = PRESSURE_RATIO_IN > RATIO_W'(cfg.dual_press_limit);
        next_judge.dual_touch       = next_smooth > SPREAD_W'(cfg.dual_detect_limit);
    end

    // judgment and smoothing; calibration restarts the smoothed spread
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            SMOOTHED_SPREAD_OUT  <= '0;
            PRESS_LOW_SINGLE_OUT <= 1'b0;
            PRESS_LOW_DUAL_OUT   <= 1'b0;
            DUAL_TOUCH_OUT       <= 1'b0;
        end else if (CE_IN && CALIB_IN) begin
            SMOOTHED_SPREAD_OUT <= '0;
        end else if (CE_IN && MEAS_VALID_IN) begin
            SMOOTHED_SPREAD_OUT  <= next_smooth;
            PRESS_LOW_SINGLE_OUT <= next_judge.press_low_single;
            PRESS_LOW_DUAL_OUT   <= next_judge.press_low_dual;
            DUAL_TOUCH_OUT       <= next_judge.dual_touch;
        end
    end

    // reference resistances refreshed by calibration
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            X_REF_OUT <= '0;
            Y_REF_OUT <= '0;
        end else if (CE_IN && CALIB_IN && REF_UPDATE_EN_IN) begin
            X_REF_OUT <= X_RES_IN;
            Y_REF_OUT <= Y_RES_IN;
        end
    end

    // X and Y dual quantities share one calculator design
    tdj_dual_calc #(.DIST_W(DIST_W), .OUT_W(DIST_W)) x_calc (
        .clk_in       (CLK_IN),
        .rst_b_in     (RST_B_IN),
        .ce_in        (CE_IN),
        .valid_in     (MEAS_VALID_IN),
        .dist_in      (X_DIST_IN),
        .slope_in     (cfg.x_slope_const),
        .bias_in      (cfg.x_bias_const),
        .quantity_out (X_DUAL_OUT)
    );
    tdj_dual_calc #(.DIST_W(DIST_W), .OUT_W(DIST_W)) y_calc (
        .clk_in       (CLK_IN),
        .rst_b_in     (RST_B_IN),
        .ce_in        (CE_IN),
        .valid_in     (MEAS_VALID_IN),
        .dist_in      (Y_DIST_IN),
        .slope_in     (cfg.y_slope_const),
        .bias_in      (cfg.y_bias_const),
        .quantity_out (Y_DUAL_OUT)
    );

    // settling delay before conversion; direct panels start at once
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state          <= TDJ_ST_IDLE;
            settle_cnt     <= '0;
            START_CONV_OUT <= 1'b0;
        end else if (CE_IN) begin
            START_CONV_OUT <= 1'b0;
            case (state)
                TDJ_ST_IDLE: begin
                    if (DRIVER_ON_IN && RES_PANEL_IN) begin
                        settle_cnt <= SETTLE_CYC[cfg.settle_delay_select] - `TDJ_SETTLE_CW'(1);
                        state      <= TDJ_ST_WAIT;
                    end else if (DRIVER_ON_IN) begin
                        START_CONV_OUT <= 1'b1;
                    end
                end
                TDJ_ST_WAIT: begin
                    if (settle_cnt == '0) begin
                        START_CONV_OUT <= 1'b1;
                        state          <= TDJ_ST_IDLE;
                    end else begin
                        settle_cnt <= settle_cnt - `TDJ_SETTLE_CW'(1);
                    end
                end
                default: state <= TDJ_ST_IDLE;
            endcase
        end
    end

    assign SETTLING_OUT = (state == TDJ_ST_WAIT);

    // helper: cycles spent settling, and the length asked for
    logic [`TDJ_SETTLE_CW-1:0] span;
    logic [`TDJ_SETTLE_CW-1:0] span_want;
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            span      <= '0;
            span_want <= '0;
        end else if (CE_IN && state == TDJ_ST_IDLE && DRIVER_ON_IN && RES_PANEL_IN) begin
            span      <= `TDJ_SETTLE_CW'(1);
            span_want <= SETTLE_CYC[cfg.settle_delay_select];
        end else if (CE_IN && state == TDJ_ST_WAIT && settle_cnt != '0) begin
            span <= span + `TDJ_SETTLE_CW'(1);
        end
    end

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    settle_length_a: assert property (CE_IN && state == TDJ_ST_WAIT && settle_cnt == '0 |-> span == span_want)
        else $error("settling length differs from selection");
    settle_start_a: assert property (CE_IN && state == TDJ_ST_WAIT && settle_cnt == '0 |=> START_CONV_OUT)
        else $error("conversion did not start after settling");
    single_press_a: assert property (CE_IN && MEAS_VALID_IN && !CALIB_IN
        |=> PRESS_LOW_SINGLE_OUT == ($past(PRESSURE_RATIO_IN) / 4 > $past(cfg.single_press_limit)))
        else $error("single pressure flag wrong");
    dual_press_a: assert property (CE_IN && MEAS_VALID_IN && !CALIB_IN
        |=> PRESS_LOW_DUAL_OUT == ($past(PRESSURE_RATIO_IN) > $past(cfg.dual_press_limit)))
        else $error("dual pressure flag wrong");
    dual_judge_a: assert property (CE_IN && MEAS_VALID_IN && !CALIB_IN
        |=> DUAL_TOUCH_OUT == (SMOOTHED_SPREAD_OUT > $past(cfg.dual_detect_limit)))
        else $error("dual judgment wrong");
    spread_offset_a: assert property (CE_IN && MEAS_VALID_IN && !CALIB_IN && !SMOOTH_EN_IN
        && SPREAD_RAW_IN > SPREAD_W'(cfg.spread_offset)
        |=> SMOOTHED_SPREAD_OUT == $past(SPREAD_RAW_IN) - SPREAD_W'($past(cfg.spread_offset)))
        else $error("spread offset not applied");
    ref_update_a: assert property (CE_IN && CALIB_IN && REF_UPDATE_EN_IN
        |=> X_REF_OUT == $past(X_RES_IN) && Y_REF_OUT == $past(Y_RES_IN))
        else $error("references not refreshed");
    ref_hold_a: assert property (CE_IN && CALIB_IN && !REF_UPDATE_EN_IN |=> $stable(X_REF_OUT) && $stable(Y_REF_OUT))
        else $error("references changed without update");
    reserved_zero_a: assert property (CE_IN && REG_RD_IN && REG_ADDR_IN == `TDJ_ADDR_CFG
        |=> REG_RDATA_OUT[7] == 1'b0 && REG_RDATA_OUT[3] == 1'b0)
        else $error("reserved bits read nonzero");

    settle_done_c: cover property (state == TDJ_ST_WAIT ##1 START_CONV_OUT);
    dual_seen_c:   cover property (CE_IN && MEAS_VALID_IN ##1 DUAL_TOUCH_OUT && PRESS_LOW_DUAL_OUT);
    calib_upd_c:   cover property (CE_IN && CALIB_IN && REF_UPDATE_EN_IN);
endmodule // tdj_judge
`default_nettype wire

// [rtl/tdj_map.svh]
// register map, reset values, field positions and timing figures of the touch judgment block
`ifndef TDJ_MAP_SVH
`define TDJ_MAP_SVH

// register indices
`define TDJ_ADDR_CFG      8'h03
`define TDJ_ADDR_SPRESS   8'h04
`define TDJ_ADDR_DPRESS   8'h05
`define TDJ_ADDR_DETECT   8'h06
`define TDJ_ADDR_OFFSET   8'h07
`define TDJ_ADDR_XSLOPE   8'h08
`define TDJ_ADDR_XBIAS    8'h09
`define TDJ_ADDR_YSLOPE   8'h0A
`define TDJ_ADDR_YBIAS    8'h0B

// reset values
`define TDJ_RST_CORR      3'h2
`define TDJ_RST_SETTLE    3'h0
`define TDJ_RST_SPRESS    8'hC0
`define TDJ_RST_DPRESS    8'hC0
`define TDJ_RST_DETECT    8'h08
`define TDJ_RST_OFFSET    8'h00
`define TDJ_RST_SLOPE     8'h02
`define TDJ_RST_BIAS      8'h40

// fields of the interval and correction register
`define TDJ_CORR_LSB      4
`define TDJ_CORR_MSB      6
`define TDJ_SETTLE_LSB    0
`define TDJ_SETTLE_MSB    2
`define TDJ_CORR_LIMIT    3'h4

// settling figures in microseconds and the clock rate
`define TDJ_CLK_MHZ       125
`define TDJ_SET_US0       5
`define TDJ_SET_US1       10
`define TDJ_SET_US2       20
`define TDJ_SET_US3       50
`define TDJ_SET_US4       100
`define TDJ_SET_US5       200
`define TDJ_SET_US6       500
`define TDJ_SET_US7       700
`define TDJ_SETTLE_CW     17

`endif

// [rtl/tdj_pkg.sv]
// types shared by the touch judgment block
`default_nettype none
`include "tdj_map.svh"
package tdj_pkg;

    // software-written parameters
    typedef struct packed {
        logic [2:0] ratio_correction;
        logic [2:0] settle_delay_select;
        logic [7:0] single_press_limit;
        logic [7:0] dual_press_limit;
        logic [7:0] dual_detect_limit;
        logic [7:0] spread_offset;
        logic [7:0] x_slope_const;
        logic [7:0] x_bias_const;
        logic [7:0] y_slope_const;
        logic [7:0] y_bias_const;
    } tdj_cfg_t;

    // judgment results of one measurement
    typedef struct packed {
        logic press_low_single;
        logic press_low_dual;
        logic dual_touch;
    } tdj_judge_t;

    typedef enum logic [1:0] {
        TDJ_ST_IDLE = 2'b01,
        TDJ_ST_WAIT = 2'b10
    } tdj_state_t;

endpackage
`default_nettype wire

// [rtl/tdj_dual_calc.sv]
// slope and bias calculation of one dual-touch quantity
`default_nettype none
`include "tdj_map.svh"
module tdj_dual_calc
    import tdj_pkg::*;
#(
    parameter int DIST_W = 12,
    parameter int OUT_W  = 12
) (
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              ce_in,
    input  wire logic              valid_in,
    input  wire logic [DIST_W-1:0] dist_in,
    input  wire logic [7:0]        slope_in,
    input  wire logic [7:0]        bias_in,
    output logic      [OUT_W-1:0]  quantity_out
);
    logic [DIST_W+7:0] prod;
    logic [DIST_W+7:0] next_quantity;
    localparam logic [DIST_W+7:0] OUT_MAX = (DIST_W+8)'({OUT_W{1'b1}});

    // distance times slope, less bias, clamped at zero and at full scale
    always_comb begin
        prod = dist_in * slope_in;
        if (prod <= (DIST_W+8)'(bias_in)) begin
            next_quantity = '0;
        end else begin
            next_quantity = prod - (DIST_W+8)'(bias_in);
        end
        if (next_quantity > OUT_MAX) begin
            next_quantity = OUT_MAX;
        end
    end

    // result held until the next measurement
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            quantity_out <= '0;
        end else if (ce_in && valid_in) begin
            quantity_out <= next_quantity[OUT_W-1:0];
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    calc_result_a: assert property (ce_in && valid_in && (dist_in * slope_in) <= (DIST_W+8)'(bias_in)
        |=> quantity_out == '0)
        else $error("dual quantity not clamped at zero");
endmodule // tdj_dual_calc
`default_nettype wire

// [tb/tdj_host_model.sv]
// host controller model that programs the judgment registers one byte at a time
`default_nettype none
`include "tdj_map.svh"
module tdj_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output var  logic [7:0] addr_out,
    output var  logic [7:0] wdata_out,
    output var  logic       wr_out,
    output var  logic       rd_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle from time zero
    initial begin
        addr_out  = 8'h00;
        wdata_out = 8'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end

    // one-cycle write strobe; released data is inverted so stale bytes never look valid
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == `TDJ_ADDR_CFG) begin
            v = d & 8'h37;
        end
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= v;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        wdata_out <= ~v;
    endtask

    // read data is registered, so it is taken just after the strobe's edge
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
endmodule // tdj_host_model
`default_nettype wire

// [tb/tdj_judge_tb.sv]
// self-checking testbench of the touch judgment block
`default_nettype none
`include "tdj_map.svh"
module tdj_judge_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] RST_VAL [9] = '{8'h20, 8'hC0, 8'hC0, 8'h08, 8'h00, 8'h02, 8'h40, 8'h02, 8'h40};

    logic        clk, rst_b, ce, wr, rd, mv, smooth, calib, ref_en, drv, res_panel;
    logic        settling, start, pls, pld, dual;
    logic [7:0]  addr, wdata, rdata, spread_raw, sm_spread;
    logic [9:0]  ratio;
    logic [11:0] xd, yd, xq, yq;
    logic [15:0] xres, yres, xref, yref;
    logic [2:0]  corr;
    int          mismatches, n_compared;

    // short settle table keeps the run brief: select k waits k+2 cycles
    tdj_judge #(.SETTLE_CYC('{17'h2, 17'h3, 17'h4, 17'h5, 17'h6, 17'h7, 17'h8, 17'h9})) DUT (
        .CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .MEAS_VALID_IN(mv),
        .PRESSURE_RATIO_IN(ratio), .SPREAD_RAW_IN(spread_raw), .SMOOTH_EN_IN(smooth),
        .X_DIST_IN(xd), .Y_DIST_IN(yd), .CALIB_IN(calib), .REF_UPDATE_EN_IN(ref_en),
        .X_RES_IN(xres), .Y_RES_IN(yres), .DRIVER_ON_IN(drv), .RES_PANEL_IN(res_panel),
        .SETTLING_OUT(settling), .START_CONV_OUT(start), .PRESS_LOW_SINGLE_OUT(pls),
        .PRESS_LOW_DUAL_OUT(pld), .DUAL_TOUCH_OUT(dual), .SMOOTHED_SPREAD_OUT(sm_spread),
        .X_DUAL_OUT(xq), .Y_DUAL_OUT(yq), .X_REF_OUT(xref), .Y_REF_OUT(yref),
        .RATIO_CORRECTION_OUT(corr));

    tdj_host_model host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd));

    // 125 MHz clock
    always #4 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // one measurement strobe; ratio, spread and distances inverted afterwards so stale values cannot pass
    task automatic meas(input logic [9:0] r, input logic [7:0] s, input logic sm,
                        input logic [11:0] x, input logic [11:0] y);
        @(posedge clk);
        mv <= 1'b1; ratio <= r; spread_raw <= s; smooth <= sm; xd <= x; yd <= y;
        @(posedge clk);
        mv <= 1'b0; ratio <= ~r; spread_raw <= ~s; xd <= ~x; yd <= ~y;
        #1;
    endtask

    task automatic t_reset();
        logic [7:0] d;
        for (int i = 0; i < 9; i++) begin
            host.reg_read(8'(i + 3), d);
            chk(d, RST_VAL[i]);
        end
        host.reg_read(8'h0C, d);
        chk(d, 8'h00);
        chk(corr, 3'h2);
    endtask

    task automatic t_regs();
        logic [7:0] d;
        for (int i = 4; i < 12; i++) host.reg_write(8'(i), 8'(8'h5A + i));
        host.reg_write(`TDJ_ADDR_CFG, 8'hFF);
        host.reg_write(8'h0C, 8'h11);
        for (int i = 4; i < 12; i++) begin
            host.reg_read(8'(i), d);
            chk(d, 8'(8'h5A + i));
        end
        host.reg_read(`TDJ_ADDR_CFG, d);
        chk(d, 8'h37);
        chk(corr, 3'h3);
        host.reg_read(8'h0C, d);
        chk(d, 8'h00);
    endtask

    // limit boundaries: equal is sufficient, one above is insufficient
    task automatic t_press();
        logic [9:0] rr [3] = '{10'h040, 10'h043, 10'h044};
        logic       es [3] = '{1'b0, 1'b0, 1'b1};
        logic       ed [3] = '{1'b0, 1'b1, 1'b1};
        host.reg_write(`TDJ_ADDR_SPRESS, 8'h10);
        host.reg_write(`TDJ_ADDR_DPRESS, 8'h40);
        for (int i = 0; i < 3; i++) begin
            meas(rr[i], 8'h00, 1'b0, 12'h000, 12'h000);
            chk(pls, es[i]);
            chk(pld, ed[i]);
        end
    endtask

    task automatic t_spread();
        logic [7:0] raw [5] = '{8'h0D, 8'h0E, 8'h03, 8'h0E, 8'h0A};
        logic       smt [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        logic [7:0] esm [5] = '{8'h08, 8'h09, 8'h00, 8'h09, 8'h07};
        logic       edl [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        host.reg_write(`TDJ_ADDR_OFFSET, 8'h05);
        host.reg_write(`TDJ_ADDR_DETECT, 8'h08);
        for (int i = 0; i < 5; i++) begin
            meas(10'h000, raw[i], smt[i], 12'h000, 12'h000);
            chk(sm_spread, esm[i]);
            chk(dual, edl[i]);
        end
    endtask

    // clock enable low must freeze registers and judgment alike
    task automatic t_freeze();
        logic [7:0] d;
        @(posedge clk);
        ce <= 1'b0;
        host.reg_write(`TDJ_ADDR_DETECT, 8'h33);
        meas(10'h3FF, 8'h20, 1'b0, 12'h000, 12'h000);
        chk(sm_spread, 8'h07);
        chk(pls, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        host.reg_read(`TDJ_ADDR_DETECT, d);
        chk(d, 8'h08);
    endtask

    // negative result clamps to zero, overflow clamps to full scale
    task automatic t_dual();
        host.reg_write(`TDJ_ADDR_XSLOPE, 8'h03);
        host.reg_write(`TDJ_ADDR_XBIAS, 8'h10);
        host.reg_write(`TDJ_ADDR_YSLOPE, 8'h02);
        host.reg_write(`TDJ_ADDR_YBIAS, 8'h40);
        meas(10'h000, 8'h00, 1'b0, 12'h020, 12'h010);
        chk(xq, 12'h050);
        chk(yq, 12'h000);
        meas(10'h000, 8'h00, 1'b0, 12'hFFF, 12'h060);
        chk(xq, 12'hFFF);
        chk(yq, 12'h080);
    endtask

    // a nonzero smoothed spread first, so the clear can be seen; a measurement in the same cycle loses
    task automatic t_calib(input logic en, input logic [15:0] ex, input logic [15:0] ey);
        meas(10'h000, 8'h10, 1'b0, 12'h000, 12'h000);
        chk(sm_spread, 8'h0B);
        @(posedge clk);
        calib <= 1'b1; ref_en <= en; xres <= 16'h1234; yres <= 16'hABCD;
        mv <= 1'b1; spread_raw <= 8'h20;
        @(posedge clk);
        calib <= 1'b0; xres <= 16'hEDCB; yres <= 16'h5432;
        mv <= 1'b0;
        #1;
        chk(xref, ex);
        chk(yref, ey);
        chk(sm_spread, 8'h00);
    endtask

    // counts cycles from the edge that raises driver-on to the conversion start
    task automatic settle(input logic rp, input int expk);
        int k;
        @(posedge clk);
        drv <= 1'b1; res_panel <= rp;
        @(posedge clk);
        drv <= 1'b0; res_panel <= ~rp;
        #1;
        k = 1;
        while (start !== 1'b1 && k < 40) begin
            chk(settling, rp);
            @(posedge clk);
            #1;
            k++;
        end
        chk(k, expk);
        chk(settling, 1'b0);
    endtask

    task automatic t_settle();
        for (int s = 0; s < 8; s++) begin
            host.reg_write(`TDJ_ADDR_CFG, {1'b0, 3'h2, 1'b0, 3'(s)});
            settle(1'b1, s + 3);
        end
        settle(1'b0, 1);
    endtask

    // main sequence
    initial begin
        clk = 1'b0; rst_b = 1'b0; ce = 1'b1; mv = 1'b0; ratio = 10'h000; spread_raw = 8'h00;
        smooth = 1'b0; xd = 12'h000; yd = 12'h000; calib = 1'b0; ref_en = 1'b0;
        xres = 16'h0000; yres = 16'h0000; drv = 1'b0; res_panel = 1'b0;
        mismatches = 0; n_compared = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_regs();
        t_press();
        t_spread();
        t_freeze();
        t_dual();
        t_calib(1'b0, 16'h0000, 16'h0000);
        t_calib(1'b1, 16'h1234, 16'hABCD);
        t_settle();
        print_verdict();
    end

    // watchdog, well beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule // tdj_judge_tb
`default_nettype wire
